/* File: rtl/tccu_top.sv */
`timescale 1ns/1ps
`include "tccu_defines.svh"
module tccu_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic count_input_pin,
    input wire logic reload_pin,
    input wire logic [3:0] capture_input_pin,
    output logic [3:0] compare_output_pin,
    output logic [3:0] compare_output_oe,
    output logic timer_irq,
    output logic [3:0] compare_irq
);

    tccu_pkg::tccu_tcon_s tcon_q;
    logic [7:0] mcfg_q;
    logic [7:0] irq_enable_main_q;
    logic [7:0] irq_enable_ext_q;
    logic [7:0] latch_q;
    logic [15:0] cnt_q;
    logic [15:0] mod_q [4];
    logic flag_ovf_q;
    logic flag_rld_q;
    logic [3:0] flag_cmp_q;
    logic [3:0] eq_prev_q;
    logic [3:0] cmp_out_q;
    logic [4:0] div_q;
    logic [`TCCU_NUM_PINS-1:0] sync1_q;
    logic [`TCCU_NUM_PINS-1:0] sync2_q;
    logic [`TCCU_NUM_PINS-1:0] sync3_q;
    logic [31:0] prdata_q;
    logic timer_irq_q;
    logic [3:0] compare_irq_q;

    logic [7:0] idx;
    logic addr_ok;
    logic mapped;
    logic wr_en;
    logic [7:0] rd_byte;
    logic presc_tick;
    logic inc;
    logic ovf_evt;
    logic rld_evt;
    logic [3:0] eq;
    logic [3:0] cmp_set;
    logic [3:0] cap_evt;
    logic [3:0] pin_rise;
    logic [3:0] pin_fall;
    tccu_pkg::tccu_func_e func [4];
    logic [4:0] div_last;

    // APB decode
    assign idx = paddr[9:2];
    assign addr_ok = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite && mapped;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_q;

    always_comb begin
        mapped = addr_ok;
        rd_byte = `TCCU_RST_BYTE;
        case (idx)
            `TCCU_IDX_TCON: rd_byte = tcon_q;
            `TCCU_IDX_MCFG: rd_byte = mcfg_q;
            `TCCU_IDX_CNTH: rd_byte = cnt_q[15:8];
            `TCCU_IDX_CNTL: rd_byte = cnt_q[7:0];
            `TCCU_IDX_M0H: rd_byte = mod_q[0][15:8];
            `TCCU_IDX_M0L: rd_byte = mod_q[0][7:0];
            `TCCU_IDX_M1H: rd_byte = mod_q[1][15:8];
            `TCCU_IDX_M1L: rd_byte = mod_q[1][7:0];
            `TCCU_IDX_M2H: rd_byte = mod_q[2][15:8];
            `TCCU_IDX_M2L: rd_byte = mod_q[2][7:0];
            `TCCU_IDX_M3H: rd_byte = mod_q[3][15:8];
            `TCCU_IDX_M3L: rd_byte = mod_q[3][7:0];
            `TCCU_IDX_IRQ_ENABLE_MAIN: rd_byte = irq_enable_main_q;
            `TCCU_IDX_IRQ_ENABLE_EXT: rd_byte = irq_enable_ext_q;
            `TCCU_IDX_IRQF: rd_byte = {flag_rld_q, flag_ovf_q, flag_cmp_q,
                                       2'h0};
            `TCCU_IDX_LATCH: rd_byte = latch_q;
            default: mapped = 1'b0;
        endcase
    end

    // read data captured in the setup cycle, shown in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else if (psel && !penable) begin
            prdata_q <= {24'h000000, rd_byte};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcon_q <= tccu_pkg::tccu_tcon_s'(`TCCU_RST_BYTE);
            mcfg_q <= `TCCU_RST_BYTE;
            irq_enable_main_q <= `TCCU_RST_BYTE;
            irq_enable_ext_q <= `TCCU_RST_BYTE;
            latch_q <= `TCCU_RST_BYTE;
        end else if (wr_en) begin
            case (idx)
                `TCCU_IDX_TCON: tcon_q <= tccu_pkg::tccu_tcon_s'(pwdata[7:0]);
                `TCCU_IDX_MCFG: mcfg_q <= pwdata[7:0];
                `TCCU_IDX_IRQ_ENABLE_MAIN: irq_enable_main_q <= pwdata[7:0] & `TCCU_IRQ_ENABLE_MAIN_MASK;
                `TCCU_IDX_IRQ_ENABLE_EXT: irq_enable_ext_q <= pwdata[7:0] & `TCCU_IRQ_ENABLE_EXT_MASK;
                `TCCU_IDX_LATCH: latch_q <= pwdata[7:0] & `TCCU_LATCH_MASK;
                default: ;
            endcase
        end
    end

    // two-flop synchronisers; only sync2/sync3 feed edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= {capture_input_pin, reload_pin, count_input_pin};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign pin_rise = sync2_q[`TCCU_PIN_CAP0 +: 4] &
                      ~sync3_q[`TCCU_PIN_CAP0 +: 4];
    assign pin_fall = ~sync2_q[`TCCU_PIN_CAP0 +: 4] &
                      sync3_q[`TCCU_PIN_CAP0 +: 4];

    // prescaler free-runs so gating never shifts the phase
    assign div_last = tcon_q.prescale_select ? `TCCU_DIV24_LAST
                                             : `TCCU_DIV12_LAST;
    assign presc_tick = (div_q >= div_last);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= `TCCU_DIV_ZERO;
        end else if (presc_tick) begin
            div_q <= `TCCU_DIV_ZERO;
        end else begin
            div_q <= div_q + 5'h01;
        end
    end

    always_comb begin
        case (tcon_q.count_control)
            tccu_pkg::CNT_PRESC: inc = presc_tick;
            tccu_pkg::CNT_GATED:
                inc = presc_tick && sync2_q[`TCCU_PIN_COUNT];
            tccu_pkg::CNT_PIN: inc = sync2_q[`TCCU_PIN_COUNT] &&
                                     !sync3_q[`TCCU_PIN_COUNT];
            default: inc = 1'b0;
        endcase
    end

    assign ovf_evt = inc && (cnt_q == `TCCU_CNT_MAX);
    assign rld_evt = (tcon_q.reload_select == tccu_pkg::RLD_PIN) &&
                     !sync2_q[`TCCU_PIN_RELOAD] &&
                     sync3_q[`TCCU_PIN_RELOAD];

    // software write wins over reload and counting in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= `TCCU_RST_WORD;
        end else if (wr_en && idx == `TCCU_IDX_CNTH) begin
            cnt_q[15:8] <= pwdata[7:0];
        end else if (wr_en && idx == `TCCU_IDX_CNTL) begin
            cnt_q[7:0] <= pwdata[7:0];
        end else if (rld_evt) begin
            cnt_q <= mod_q[0];
        end else if (ovf_evt &&
                     tcon_q.reload_select == tccu_pkg::RLD_OVF) begin
            cnt_q <= mod_q[0];
        end else if (inc) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // per-module compare and capture
    generate
        for (genvar i = 0; i < 4; i++) begin : g_mod
            assign func[i] =
                tccu_pkg::tccu_func_e'(mcfg_q[2*i +: 2]);
            assign eq[i] = (cnt_q == mod_q[i]);
            if (i == 0) begin : g_m0
                assign cmp_set[i] = (func[i] == tccu_pkg::FN_COMPARE) &&
                    (tcon_q.com0_edge_select ? (eq[i] && !eq_prev_q[i])
                        : (!eq[i] && eq_prev_q[i]));
                assign cap_evt[i] = (func[i] == tccu_pkg::FN_CAP_PIN) &&
                    (tcon_q.com0_edge_select ? pin_rise[i]
                                             : pin_fall[i]);
            end else begin : g_mn
                assign cmp_set[i] = (func[i] == tccu_pkg::FN_COMPARE) &&
                                    eq[i] && !eq_prev_q[i];
                assign cap_evt[i] = (func[i] == tccu_pkg::FN_CAP_PIN) &&
                                    pin_rise[i];
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                mod_q[i] <= `TCCU_RST_WORD;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_en && idx == `TCCU_IDX_MLO(i)
                    && func[i] == tccu_pkg::FN_CAP_WRITE) begin
                    mod_q[i] <= cnt_q;
                end else if (wr_en && idx == `TCCU_IDX_MLO(i)) begin
                    mod_q[i][7:0] <= pwdata[7:0];
                end else if (wr_en && idx == `TCCU_IDX_MHI(i)) begin
                    mod_q[i][15:8] <= pwdata[7:0];
                end else if (cap_evt[i]) begin
                    mod_q[i] <= cnt_q;
                end
            end
        end
    end

    // compare pins; indirect mode holds level across overflow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_out_q <= 4'h0;
            eq_prev_q <= 4'h0;
        end else begin
            eq_prev_q <= eq;
            for (int i = 0; i < 4; i++) begin
                if (!tcon_q.compare_output_method) begin
                    cmp_out_q[i] <= (cnt_q >= mod_q[i]);
                end else if (eq[i]) begin
                    cmp_out_q[i] <= latch_q[i];
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            compare_output_oe[i] = (func[i] == tccu_pkg::FN_COMPARE);
        end
    end
    assign compare_output_pin = cmp_out_q;

    // flags: hardware set beats a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_ovf_q <= 1'b0;
            flag_rld_q <= 1'b0;
            flag_cmp_q <= 4'h0;
        end else begin
            if (wr_en && idx == `TCCU_IDX_IRQF) begin
                flag_ovf_q <= pwdata[`TCCU_BIT_FLAG_OVF] || ovf_evt;
                flag_rld_q <= pwdata[`TCCU_BIT_FLAG_RELOAD] ||
                              (rld_evt && irq_enable_ext_q[`TCCU_BIT_EN_RELOAD] &&
                               irq_enable_main_q[`TCCU_BIT_EN_TIMER]);
                flag_cmp_q <= pwdata[`TCCU_BIT_FLAG_CMP0 +: 4] | cmp_set;
            end else begin
                flag_ovf_q <= flag_ovf_q || ovf_evt;
                flag_rld_q <= flag_rld_q ||
                              (rld_evt && irq_enable_ext_q[`TCCU_BIT_EN_RELOAD] &&
                               irq_enable_main_q[`TCCU_BIT_EN_TIMER]);
                flag_cmp_q <= flag_cmp_q | cmp_set;
            end
        end
    end

    // overflow and reload share one request line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_irq_q <= 1'b0;
            compare_irq_q <= 4'h0;
        end else begin
            timer_irq_q <= irq_enable_main_q[`TCCU_BIT_EN_TIMER] &&
                           (flag_ovf_q || flag_rld_q);
            compare_irq_q <= flag_cmp_q &
                             irq_enable_ext_q[`TCCU_BIT_EN_CMP0 +: 4];
        end
    end
    assign timer_irq = timer_irq_q;
    assign compare_irq = compare_irq_q;

    logic cnt_wr;
    assign cnt_wr = wr_en && (idx == `TCCU_IDX_CNTH || idx == `TCCU_IDX_CNTL);

    property p_off_stable;
        @(posedge pclk) disable iff (!presetn)
        (tcon_q.count_control == tccu_pkg::CNT_OFF) && !cnt_wr && !rld_evt
        |=> $stable(cnt_q);
    endproperty
    a_off_stable: assert property (p_off_stable)
        else $error("counter moved while disabled");

    property p_div12;
        @(posedge pclk) disable iff (!presetn)
        presc_tick && !tcon_q.prescale_select && $stable(tcon_q)
        |=> !presc_tick [*8];
    endproperty
    a_div12: assert property (p_div12)
        else $error("prescale tick too soon");

    property p_gate_hold;
        @(posedge pclk) disable iff (!presetn)
        (tcon_q.count_control == tccu_pkg::CNT_GATED) &&
        !sync2_q[`TCCU_PIN_COUNT] && !cnt_wr && !rld_evt
        |=> $stable(cnt_q);
    endproperty
    a_gate_hold: assert property (p_gate_hold)
        else $error("counter moved while gated");

    property p_pin_count;
        @(posedge pclk) disable iff (!presetn)
        (tcon_q.count_control == tccu_pkg::CNT_PIN) && inc && !ovf_evt &&
        !cnt_wr && !rld_evt
        |=> cnt_q == $past(cnt_q) + 16'h0001;
    endproperty
    a_pin_count: assert property (p_pin_count)
        else $error("pin edge did not count");

    property p_ovf_flag;
        @(posedge pclk) disable iff (!presetn)
        ovf_evt |=> flag_ovf_q ##1 (timer_irq == irq_enable_main_q[`TCCU_BIT_EN_TIMER]);
    endproperty
    a_ovf_flag: assert property (p_ovf_flag)
        else $error("overflow flag or request missing");

    property p_ovf_reload;
        @(posedge pclk) disable iff (!presetn)
        ovf_evt && tcon_q.reload_select == tccu_pkg::RLD_OVF && !cnt_wr &&
        !rld_evt |=> cnt_q == $past(mod_q[0]);
    endproperty
    a_ovf_reload: assert property (p_ovf_reload)
        else $error("overflow reload wrong");

    property p_pin_reload;
        @(posedge pclk) disable iff (!presetn)
        rld_evt && !cnt_wr |=> cnt_q == $past(mod_q[0]);
    endproperty
    a_pin_reload: assert property (p_pin_reload)
        else $error("pin reload wrong");

    property p_direct;
        @(posedge pclk) disable iff (!presetn)
        !tcon_q.compare_output_method
        |=> cmp_out_q[1] == ($past(cnt_q) >= $past(mod_q[1]));
    endproperty
    a_direct: assert property (p_direct)
        else $error("direct compare level wrong");

    property p_indirect_hold;
        @(posedge pclk) disable iff (!presetn)
        tcon_q.compare_output_method && !eq[2] |=> $stable(cmp_out_q[2]);
    endproperty
    a_indirect_hold: assert property (p_indirect_hold)
        else $error("indirect pin changed without match");

    property p_cap_pin;
        @(posedge pclk) disable iff (!presetn)
        cap_evt[2] && !wr_en |=> mod_q[2] == $past(cnt_q);
    endproperty
    a_cap_pin: assert property (p_cap_pin)
        else $error("pin capture wrong");

endmodule

/* File: rtl/tccu_defines.svh */
`ifndef TCCU_DEFINES_SVH
`define TCCU_DEFINES_SVH

// register indices; byte address is four times the index
`define TCCU_IDX_TCON 8'hC8
`define TCCU_IDX_MCFG 8'hC1
`define TCCU_IDX_CNTH 8'hCD
`define TCCU_IDX_CNTL 8'hCC
`define TCCU_IDX_M0H 8'hCB
`define TCCU_IDX_M0L 8'hCA
`define TCCU_IDX_M3H 8'hC7
`define TCCU_IDX_M3L 8'hC6
`define TCCU_IDX_M2H 8'hC5
`define TCCU_IDX_M2L 8'hC4
`define TCCU_IDX_M1H 8'hC3
`define TCCU_IDX_M1L 8'hC2
`define TCCU_IDX_IRQ_ENABLE_MAIN 8'hA8
`define TCCU_IDX_IRQ_ENABLE_EXT 8'hB8
`define TCCU_IDX_IRQF 8'hC0
`define TCCU_IDX_LATCH 8'hD0
// byte registers of module n; module 0 sits apart from 1..3
`define TCCU_IDX_MLO(n) ((n) == 0 ? `TCCU_IDX_M0L : \
    (n) == 1 ? `TCCU_IDX_M1L : (n) == 2 ? `TCCU_IDX_M2L : `TCCU_IDX_M3L)
`define TCCU_IDX_MHI(n) ((n) == 0 ? `TCCU_IDX_M0H : \
    (n) == 1 ? `TCCU_IDX_M1H : (n) == 2 ? `TCCU_IDX_M2H : `TCCU_IDX_M3H)

`define TCCU_RST_BYTE 8'h00
`define TCCU_RST_WORD 16'h0000
`define TCCU_CNT_MAX 16'hFFFF
`define TCCU_IRQ_ENABLE_MAIN_MASK 8'hA0
`define TCCU_IRQ_ENABLE_EXT_MASK 8'hBC
`define TCCU_LATCH_MASK 8'h0F

// bit positions
`define TCCU_BIT_EN_TIMER 5
`define TCCU_BIT_EN_RELOAD 7
`define TCCU_BIT_EN_CMP0 2
`define TCCU_BIT_FLAG_RELOAD 7
`define TCCU_BIT_FLAG_OVF 6
`define TCCU_BIT_FLAG_CMP0 2

// pin vector layout after synchronising
`define TCCU_PIN_COUNT 0
`define TCCU_PIN_RELOAD 1
`define TCCU_PIN_CAP0 2
`define TCCU_NUM_PINS 6

// prescaler terminal counts
`define TCCU_DIV12_LAST 5'h0B
`define TCCU_DIV24_LAST 5'h17
`define TCCU_DIV_ZERO 5'h00

`endif

/* File: rtl/tccu_pkg.sv */
package tccu_pkg;

    typedef enum logic [1:0] {
        CNT_OFF = 2'b00,
        CNT_PRESC = 2'b01,
        CNT_PIN = 2'b10,
        CNT_GATED = 2'b11
    } tccu_count_e;

    typedef enum logic [1:0] {
        RLD_OFF0 = 2'b00,
        RLD_OFF1 = 2'b01,
        RLD_OVF = 2'b10,
        RLD_PIN = 2'b11
    } tccu_reload_e;

    typedef enum logic [1:0] {
        FN_OFF = 2'b00,
        FN_CAP_PIN = 2'b01,
        FN_COMPARE = 2'b10,
        FN_CAP_WRITE = 2'b11
    } tccu_func_e;

    typedef struct packed {
        logic prescale_select;
        logic com0_edge_select;
        logic spare;
        tccu_reload_e reload_select;
        logic compare_output_method;
        tccu_count_e count_control;
    } tccu_tcon_s;

endpackage

/* File: testbench/tccu_pins.sv */
`timescale 1ns/1ps
module tccu_pins (
    input wire logic pclk,
    output logic count_input_pin,
    output logic reload_pin,
    output logic [3:0] capture_input_pin
);
    // reload line idles high, as on a pulled-up pin
    initial begin
        count_input_pin = 1'b0;
        reload_pin = 1'b1;
        capture_input_pin = 4'h0;
    end

    // sel 0 count, 1 reload, 2..5 capture; each level held 6 clocks,
    // keeping edges well under half the clock rate and past the synchroniser
    task automatic drive(input int sel, input logic lvl);
        @(posedge pclk);
        if (sel == 0)
            count_input_pin <= lvl;
        else if (sel == 1)
            reload_pin <= lvl;
        else
            capture_input_pin[sel-2] <= lvl;
        repeat (5) @(posedge pclk);
    endtask
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
`include "tccu_defines.svh"
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic count_input_pin, reload_pin, timer_irq;
    logic [3:0] capture_input_pin, compare_output_pin, compare_output_oe;
    logic [3:0] compare_irq;
    logic [7:0] d;
    logic [15:0] v;
    logic e;
    int miscompares = 0;
    int n_compared = 0;
    logic [7:0] tc_tab [4] = '{8'h01, 8'h81, 8'h03, 8'h03};
    int cyc_tab [4] = '{240, 480, 240, 240};
    int lo_tab [4] = '{19, 19, 0, 19};
    int hi_tab [4] = '{21, 21, 0, 21};
    logic [7:0] rst_tab [6] = '{`TCCU_IDX_TCON, `TCCU_IDX_MCFG,
        `TCCU_IDX_CNTL, `TCCU_IDX_M0H, `TCCU_IDX_IRQF, `TCCU_IDX_IRQ_ENABLE_EXT};

    tccu_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .count_input_pin(count_input_pin), .reload_pin(reload_pin),
        .capture_input_pin(capture_input_pin),
        .compare_output_pin(compare_output_pin),
        .compare_output_oe(compare_output_oe), .timer_irq(timer_irq),
        .compare_irq(compare_irq));
    tccu_pins PINS (.pclk(pclk), .count_input_pin(count_input_pin),
        .reload_pin(reload_pin), .capture_input_pin(capture_input_pin));

    always #20 pclk = ~pclk;

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] idx,
        input logic [7:0] wd, output logic [7:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            miscompares++;
            wrap_up();
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        apb(1'b1, idx, wd, d, e);
    endtask

    task automatic rd(input logic [7:0] idx);
        apb(1'b0, idx, 8'h00, d, e);
    endtask

    // high index sits one above its low byte for every pair
    task automatic wr16(input logic [7:0] hi, input logic [15:0] val);
        wr(hi, val[15:8]);
        wr(hi - 8'h01, val[7:0]);
    endtask

    task automatic rd16(input logic [7:0] hi);
        rd(hi);
        v[15:8] = d;
        rd(hi - 8'h01);
        v[7:0] = d;
    endtask

    task automatic pulse(input int n);
        repeat (n) begin
            PINS.drive(0, 1'b1);
            PINS.drive(0, 1'b0);
        end
    endtask

    initial begin
        repeat (100000) @(posedge pclk);
        miscompares++;
        wrap_up();
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rst_tab[i]) begin
            rd(rst_tab[i]);
            chk({8'h00, d}, 16'h0000);
        end
        rd(8'h10);
        chk({15'h0000, e}, 16'h0001);
        wr(`TCCU_IDX_TCON, 8'hA4);
        rd(`TCCU_IDX_TCON);
        chk({8'h00, d}, 16'h00A4);
        // prescaled and gated counting over 240 cycles, 480 at the divide-by-24 setting
        for (int i = 0; i < 4; i++) begin
            wr16(`TCCU_IDX_CNTH, 16'h0000);
            PINS.drive(0, (i == 3));
            wr(`TCCU_IDX_TCON, tc_tab[i]);
            repeat (cyc_tab[i]) @(posedge pclk);
            wr(`TCCU_IDX_TCON, 8'h00);
            rd(`TCCU_IDX_CNTL);
            chk(16'(d >= lo_tab[i] && d <= hi_tab[i]), 16'h1);
        end
        PINS.drive(0, 1'b0);
        wr16(`TCCU_IDX_CNTH, 16'hFFFE);
        wr(`TCCU_IDX_TCON, 8'h02);
        pulse(2);
        rd16(`TCCU_IDX_CNTH);
        chk(v, 16'h0000);
        rd(`TCCU_IDX_IRQF);
        chk({8'h00, d}, 16'h0040);
        chk({15'h0, timer_irq}, 16'h0000);
        wr(`TCCU_IDX_IRQ_ENABLE_MAIN, 8'h20);
        repeat (3) @(posedge pclk);
        chk({15'h0, timer_irq}, 16'h0001);
        wr(`TCCU_IDX_IRQF, 8'h00);
        repeat (3) @(posedge pclk);
        chk({15'h0, timer_irq}, 16'h0000);
        wr16(`TCCU_IDX_M0H, 16'h1230);
        wr16(`TCCU_IDX_CNTH, 16'hFFFF);
        wr(`TCCU_IDX_TCON, 8'h12);
        pulse(1);
        rd16(`TCCU_IDX_CNTH);
        chk(v, 16'h1230);
        wr16(`TCCU_IDX_CNTH, 16'h0007);
        wr(`TCCU_IDX_IRQ_ENABLE_EXT, 8'h80);
        wr(`TCCU_IDX_IRQF, 8'h00);
        wr(`TCCU_IDX_TCON, 8'h1A);
        PINS.drive(1, 1'b0);
        rd16(`TCCU_IDX_CNTH);
        chk(v, 16'h1230);
        rd(`TCCU_IDX_IRQF);
        chk({8'h00, d}, 16'h0080);
        chk({15'h0, timer_irq}, 16'h0001);
        PINS.drive(1, 1'b1);
        pulse(1);
        rd16(`TCCU_IDX_CNTH);
        chk(v, 16'h1231);
        // direct compare on module 1, then indirect
        wr(`TCCU_IDX_TCON, 8'h00);
        wr16(`TCCU_IDX_M1H, 16'h0005);
        wr16(`TCCU_IDX_CNTH, 16'h0004);
        wr(`TCCU_IDX_MCFG, 8'h08);
        wr(`TCCU_IDX_IRQF, 8'h00);
        repeat (3) @(posedge pclk);
        chk({12'h000, compare_output_oe}, 16'h0002);
        chk({15'h0, compare_output_pin[1]}, 16'h0000);
        wr(`TCCU_IDX_CNTL, 8'h05);
        repeat (3) @(posedge pclk);
        chk({15'h0, compare_output_pin[1]}, 16'h0001);
        rd(`TCCU_IDX_IRQF);
        chk({8'h00, d}, 16'h0008);
        chk({12'h000, compare_irq}, 16'h0000);
        wr(`TCCU_IDX_IRQ_ENABLE_EXT, 8'h08);
        repeat (3) @(posedge pclk);
        chk({12'h000, compare_irq}, 16'h0002);
        wr(`TCCU_IDX_LATCH, 8'h00);
        wr(`TCCU_IDX_CNTL, 8'h06);
        wr(`TCCU_IDX_TCON, 8'h04);
        repeat (3) @(posedge pclk);
        chk({15'h0, compare_output_pin[1]}, 16'h0001);
        wr(`TCCU_IDX_CNTL, 8'h05);
        repeat (3) @(posedge pclk);
        chk({15'h0, compare_output_pin[1]}, 16'h0000);
        wr(`TCCU_IDX_CNTL, 8'h06);
        wr(`TCCU_IDX_LATCH, 8'h02);
        repeat (3) @(posedge pclk);
        chk({15'h0, compare_output_pin[1]}, 16'h0000);
        // module 0 flag on becoming equal, then on becoming unequal
        wr(`TCCU_IDX_TCON, 8'h40);
        wr16(`TCCU_IDX_CNTH, 16'h1200);
        wr(`TCCU_IDX_MCFG, 8'h0A);
        wr(`TCCU_IDX_IRQF, 8'h00);
        wr(`TCCU_IDX_CNTL, 8'h30);
        repeat (3) @(posedge pclk);
        rd(`TCCU_IDX_IRQF);
        chk({8'h00, d}, 16'h0004);
        wr(`TCCU_IDX_TCON, 8'h00);
        wr(`TCCU_IDX_IRQF, 8'h00);
        repeat (3) @(posedge pclk);
        rd(`TCCU_IDX_IRQF);
        chk({8'h00, d}, 16'h0000);
        wr(`TCCU_IDX_CNTL, 8'h31);
        repeat (3) @(posedge pclk);
        rd(`TCCU_IDX_IRQF);
        chk({8'h00, d}, 16'h0004);
        // captures: m3 on write, m2 on pin, m1 off, m0 on pin
        wr(`TCCU_IDX_MCFG, 8'hD1);
        wr16(`TCCU_IDX_CNTH, 16'h1234);
        PINS.drive(4, 1'b1);
        rd16(`TCCU_IDX_M2H);
        chk(v, 16'h1234);
        PINS.drive(3, 1'b1);
        rd16(`TCCU_IDX_M1H);
        chk(v, 16'h0005);
        PINS.drive(2, 1'b1);
        wr16(`TCCU_IDX_CNTH, 16'h0ABC);
        PINS.drive(2, 1'b0);
        rd16(`TCCU_IDX_M0H);
        chk(v, 16'h0ABC);
        wr(`TCCU_IDX_TCON, 8'h40);
        wr16(`TCCU_IDX_CNTH, 16'h0DEF);
        PINS.drive(2, 1'b1);
        rd16(`TCCU_IDX_M0H);
        chk(v, 16'h0DEF);
        wr16(`TCCU_IDX_CNTH, 16'hABCD);
        wr(`TCCU_IDX_M3L, 8'h55);
        rd16(`TCCU_IDX_M3H);
        chk(v, 16'hABCD);
        wrap_up();
    end
endmodule
